// File: hw/sqw_walker.sv
// split queue descriptor walker: fetches offered heads, walks chains and one
// level of indirect table, and decides on used-buffer notifications
// assumes a same-clock memory read port that answers each held request once
`include "sqw_defines.svh"

module sqw_walker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] qsz_log2,
  input wire logic [63:0] desc_base,
  input wire logic [63:0] ring_base,
  input wire logic [15:0] offer_idx,
  input wire logic err_clr,
  output logic rd_req,
  output logic [63:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [127:0] rd_data,
  output logic buf_valid,
  output sqw_pkg::sqw_buf_s buf_out,
  input wire logic buf_ready,
  output logic chain_done,
  output logic [15:0] chain_head,
  output logic [15:0] seen_idx,
  output logic busy,
  output logic err,
  output logic [1:0] err_code,
  input wire logic event_idx_en,
  input wire logic [15:0] drv_flags,
  input wire logic [15:0] used_event,
  input wire logic used_wr,
  input wire logic [15:0] used_idx,
  output logic notify
);
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // byte address of entry idx in a 16-byte record table
  function automatic logic [63:0] rec_addr(input logic [63:0] base, input logic [27:0] idx);
    rec_addr = base + {32'h0, idx, 4'h0};
  endfunction

  sqw_pkg::sqw_state_e state, next_state;
  sqw_pkg::sqw_desc_s cur;
  logic next_rd_req, next_buf_valid, next_chain_done, next_busy, next_err;
  logic next_in_tab, in_tab, next_notify;
  logic [63:0] next_rd_addr, tab_base, next_tab_base;
  logic [27:0] tab_cnt, next_tab_cnt, steps, next_steps, limit;
  logic [15:0] next_chain_head, next_seen_idx, qmask;
  logic [1:0] next_err_code;
  sqw_pkg::sqw_buf_s next_buf_out;
  logic desc_load;

  // queue size is 2^qsz_log2, so it is a power of two by construction
  assign qmask = 16'((17'h00001 << qsz_log2) - 17'h00001);
  // chain cap: queue size in the main table, entry count inside a table
  assign limit = in_tab ? tab_cnt : {12'h000, qmask} + 28'h0000001;
  assign desc_load = rd_ack && (state == sqw_pkg::ST_DESC);

  sqw_desc_reg u_desc (
    .clk(clk),
    .rst_n(rst_n),
    .load(desc_load),
    .raw(rd_data),
    .desc(cur)
  );

  // --------------------------------------------------------------------------
  // chain walk
  // --------------------------------------------------------------------------
  // only read requests leave this block; buffers go out tagged so the data
  // engine can keep stores off readable ones and loads off writable ones
  always_comb begin
    next_state = state;
    next_rd_req = rd_req;
    next_rd_addr = rd_addr;
    next_buf_valid = buf_valid;
    next_buf_out = buf_out;
    next_chain_done = 1'b0;
    next_chain_head = chain_head;
    next_seen_idx = seen_idx;
    next_err = err;
    next_err_code = err_code;
    next_in_tab = in_tab;
    next_tab_base = tab_base;
    next_tab_cnt = tab_cnt;
    next_steps = steps;
    unique case (state)
      sqw_pkg::ST_IDLE: begin
        // a differing offer index means at least one head waits in the ring
        if (offer_idx != seen_idx) begin
          next_state = sqw_pkg::ST_RING;
          next_rd_req = 1'b1;
          next_rd_addr = ring_base + `SQW_RING_HDR + {47'h0, seen_idx & qmask, 1'b0};
        end
      end
      sqw_pkg::ST_RING: begin
        if (rd_ack) begin
          next_rd_req = 1'b0;
          next_chain_head = rd_data[15:0];
          next_in_tab = 1'b0;
          next_steps = '0;
          if (rd_data[15:0] > qmask) begin
            next_state = sqw_pkg::ST_ERR;
            next_err = 1'b1;
            next_err_code = `SQW_ERR_RANGE;
          end else begin
            next_state = sqw_pkg::ST_DESC;
            next_rd_req = 1'b1;
            next_rd_addr = rec_addr(desc_base, {12'h000, rd_data[15:0]});
          end
        end
      end
      sqw_pkg::ST_DESC: begin
        if (rd_ack) begin
          next_rd_req = 1'b0;
          next_state = sqw_pkg::ST_DECODE;
        end
      end
      sqw_pkg::ST_DECODE: begin
        if (cur.flags[`SQW_F_IND_BIT]) begin
          // a table pointer carries no data, so its write bit is never looked at
          if (in_tab || cur.flags[`SQW_F_NEXT_BIT]) begin
            next_state = sqw_pkg::ST_ERR;
            next_err = 1'b1;
            next_err_code = `SQW_ERR_FLAGS;
          end else if (cur.len[31:`SQW_DESC_LOG2] == 28'h0) begin
            next_state = sqw_pkg::ST_ERR;
            next_err = 1'b1;
            next_err_code = `SQW_ERR_RANGE;
          end else begin
            next_in_tab = 1'b1;
            next_tab_base = cur.addr;
            next_tab_cnt = cur.len[31:`SQW_DESC_LOG2];
            next_steps = '0;
            next_state = sqw_pkg::ST_DESC;
            next_rd_req = 1'b1;
            next_rd_addr = cur.addr;
          end
        end else begin
          next_state = sqw_pkg::ST_EMIT;
          next_buf_valid = 1'b1;
          next_buf_out.addr = cur.addr;
          next_buf_out.len = cur.len;
          next_buf_out.dev_write = cur.flags[`SQW_F_WRITE_BIT];
          next_buf_out.from_table = in_tab;
        end
      end
      sqw_pkg::ST_EMIT: begin
        if (buf_ready) begin
          next_buf_valid = 1'b0;
          next_steps = steps + 28'h0000001;
          if (!cur.flags[`SQW_F_NEXT_BIT]) begin
            // continue clear ends the chain, in a table or in the main ring
            next_state = sqw_pkg::ST_IDLE;
            next_chain_done = 1'b1;
            next_seen_idx = seen_idx + 16'h0001;
          end else if (steps + 28'h0000001 >= limit) begin
            next_state = sqw_pkg::ST_ERR;
            next_err = 1'b1;
            next_err_code = `SQW_ERR_LONG;
          end else if (in_tab ? ({12'h000, cur.link} >= tab_cnt) : (cur.link > qmask)) begin
            next_state = sqw_pkg::ST_ERR;
            next_err = 1'b1;
            next_err_code = `SQW_ERR_RANGE;
          end else begin
            next_state = sqw_pkg::ST_DESC;
            next_rd_req = 1'b1;
            next_rd_addr = rec_addr(in_tab ? tab_base : desc_base, {12'h000, cur.link});
          end
        end
      end
      sqw_pkg::ST_ERR: begin
        // fetching stops here; a clear skips the broken chain
        if (err_clr) begin
          next_state = sqw_pkg::ST_IDLE;
          next_err = 1'b0;
          next_err_code = `SQW_ERR_NONE;
          next_seen_idx = seen_idx + 16'h0001;
        end
      end
    endcase
    next_busy = (next_state != sqw_pkg::ST_IDLE) && (next_state != sqw_pkg::ST_ERR);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sqw_pkg::ST_IDLE;
      rd_req <= 1'b0;
      rd_addr <= '0;
      buf_valid <= 1'b0;
      buf_out <= '0;
      chain_done <= 1'b0;
      chain_head <= `SQW_IDX_RST;
      seen_idx <= `SQW_IDX_RST;
      busy <= 1'b0;
      err <= 1'b0;
      err_code <= `SQW_ERR_NONE;
      in_tab <= 1'b0;
      tab_base <= '0;
      tab_cnt <= '0;
      steps <= '0;
    end else begin
      state <= next_state;
      rd_req <= next_rd_req;
      rd_addr <= next_rd_addr;
      buf_valid <= next_buf_valid;
      buf_out <= next_buf_out;
      chain_done <= next_chain_done;
      chain_head <= next_chain_head;
      seen_idx <= next_seen_idx;
      busy <= next_busy;
      err <= next_err;
      err_code <= next_err_code;
      in_tab <= next_in_tab;
      tab_base <= next_tab_base;
      tab_cnt <= next_tab_cnt;
      steps <= next_steps;
    end
  end

  // --------------------------------------------------------------------------
  // used-buffer notification
  // --------------------------------------------------------------------------
  // 16-bit equality wraps by itself, so rollover of the used index is harmless
  always_comb begin
    next_notify = 1'b0;
    if (used_wr) begin
      if (event_idx_en) begin
        next_notify = (used_idx == used_event);
      end else begin
        next_notify = !drv_flags[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      notify <= 1'b0;
    end else begin
      notify <= next_notify;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  evt_notify_a: assert property (used_wr && event_idx_en && used_idx == used_event |=> notify)
    else $error("event index match gave no notification");
  evt_quiet_a: assert property (used_wr && event_idx_en && used_idx != used_event |=> !notify)
    else $error("notification without event index match");
  flag_notify_a: assert property (used_wr && !event_idx_en && !drv_flags[0] |=> notify)
    else $error("flags zero gave no notification");
  flag_quiet_a: assert property (used_wr && !event_idx_en && drv_flags[0] |=> !notify)
    else $error("notification while suppressed");
  both_flags_a: assert property (state == sqw_pkg::ST_DECODE && cur.flags[`SQW_F_IND_BIT]
    && cur.flags[`SQW_F_NEXT_BIT] |=> err && !rd_req)
    else $error("indirect with continue not refused");
  nested_tab_a: assert property (state == sqw_pkg::ST_DECODE && in_tab
    && cur.flags[`SQW_F_IND_BIT] |=> err_code == `SQW_ERR_FLAGS)
    else $error("nested table not refused");
  tab_enter_a: assert property (state == sqw_pkg::ST_DECODE && !in_tab
    && cur.flags[`SQW_F_IND_BIT] && !cur.flags[`SQW_F_NEXT_BIT] && cur.len[31:4] != 28'h0
    |=> rd_req && rd_addr == $past(cur.addr) && tab_cnt == $past(cur.len[31:4]))
    else $error("indirect table entry 0 not fetched");
  buf_dir_a: assert property ($rose(buf_valid) |-> buf_out.dev_write == cur.flags[`SQW_F_WRITE_BIT]
    && !cur.flags[`SQW_F_IND_BIT])
    else $error("buffer direction wrong or table pointer passed as data");
  ring_addr_a: assert property (state == sqw_pkg::ST_RING && rd_req |-> rd_addr == ring_base
    + 64'h4 + {47'h0, seen_idx & qmask, 1'b0})
    else $error("offer ring entry address wrong");
  chain_cap_a: assert property (steps <= limit)
    else $error("chain walked past its cap");
  buf_hold_a: assert property (buf_valid && !buf_ready |=> buf_valid && $stable(buf_out))
    else $error("buffer dropped before acceptance");
endmodule

// File: hw/sqw_defines.svh
// constants of the split queue descriptor walker: field positions, layout, codes
// assumes inclusion by bare name from the design modules
`ifndef SQW_DEFINES_SVH
`define SQW_DEFINES_SVH

// ----------------------------------------------------------------------------
// descriptor flag bits and record layout
// ----------------------------------------------------------------------------
`define SQW_F_NEXT_BIT 0
`define SQW_F_WRITE_BIT 1
`define SQW_F_IND_BIT 2
`define SQW_DESC_LOG2 4
`define SQW_ADDR_LSB 0
`define SQW_LEN_LSB 64
`define SQW_FLAGS_LSB 96
`define SQW_NEXT_LSB 112

// ----------------------------------------------------------------------------
// offer ring layout, reset values, error codes
// ----------------------------------------------------------------------------
`define SQW_RING_HDR 64'h0000000000000004
`define SQW_IDX_RST 16'h0000
`define SQW_ERR_NONE 2'h0
`define SQW_ERR_LONG 2'h1
`define SQW_ERR_FLAGS 2'h2
`define SQW_ERR_RANGE 2'h3

`endif

// File: hw/sqw_pkg.sv
// types shared by the walker and its descriptor register
// assumes sqw_defines.svh is on the include path
package sqw_pkg;
  // decoded descriptor record
  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] len;
    logic [15:0] flags;
    logic [15:0] link;
  } sqw_desc_s;

  // one buffer handed to the data engine
  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] len;
    logic dev_write;
    logic from_table;
  } sqw_buf_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RING, ST_DESC, ST_DECODE, ST_EMIT, ST_ERR
  } sqw_state_e;
endpackage

// File: hw/sqw_desc_reg.sv
// descriptor capture register: splits a fetched 16-byte record into fields
// assumes byte k of the record arrives on raw[8k+7:8k], in address order
`include "sqw_defines.svh"

module sqw_desc_reg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [127:0] raw,
  output sqw_pkg::sqw_desc_s desc
);
  sqw_pkg::sqw_desc_s next_desc;

  // little-endian fields fall on plain slices since bytes come in address order
  always_comb begin
    next_desc = desc;
    if (load) begin
      next_desc.addr = raw[`SQW_ADDR_LSB +: 64];
      next_desc.len = raw[`SQW_LEN_LSB +: 32];
      next_desc.flags = raw[`SQW_FLAGS_LSB +: 16];
      next_desc.link = raw[`SQW_NEXT_LSB +: 16];
    end
  end

  // holds the record until the next fetch so the walker may look at it at leisure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      desc <= '0;
    end else begin
      desc <= next_desc;
    end
  end
endmodule

// File: test/sqw_mem_model.sv
// memory model of the driver side: one byte store for rings and tables
// assumes the walker holds rd_req and rd_addr until it samples rd_ack
module sqw_mem_model (
  input wire logic clk,
  input wire logic rd_req,
  input wire logic [63:0] rd_addr,
  input wire logic slow,
  output logic rd_ack,
  output logic [127:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [63:0]];
  int wait_n;

  // only the driver writes shared memory; bytes land little-endian
  task automatic put(input logic [63:0] a, input logic [127:0] d, input int n);
    for (int k = 0; k < n; k++) begin
      mem[a + k] = d[8 * k +: 8];
    end
  endtask

  initial begin
    rd_ack = 1'b0;
    rd_data = '0;
    wait_n = 0;
  end

  // one answer per held request; slow answers add three cycles of latency
  always @(posedge clk) begin
    #1;
    if (rd_ack || rd_req !== 1'b1) begin
      rd_ack = 1'b0;
      rd_data = ~rd_data; // released data never keeps the last value
    end else if (wait_n < (slow ? 3 : 0)) begin
      wait_n++;
    end else begin
      wait_n = 0;
      rd_ack = 1'b1;
      for (int k = 0; k < 16; k++) begin
        rd_data[8 * k +: 8] = mem.exists(rd_addr + k) ? mem[rd_addr + k] : 8'h5A;
      end
    end
  end
endmodule

// File: test/split_queue_descriptor_walker_bench.sv
// bench for the descriptor walker: offers chains, serves memory, takes buffers
// assumes the walker and sqw_mem_model share one 20 MHz clock
module split_queue_descriptor_walker_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] DBASE = 64'h1000;
  localparam logic [63:0] RBASE = 64'h2000;
  localparam logic [63:0] WBUF = 64'h9000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] offer_idx = 16'h0000;
  logic err_clr = 1'b0;
  logic buf_ready = 1'b0;
  logic slow = 1'b0;
  logic event_idx_en = 1'b0;
  logic [15:0] drv_flags = 16'h0000;
  logic [15:0] used_event = 16'h0000;
  logic used_wr = 1'b0;
  logic [15:0] used_idx = 16'h0000;
  logic rd_req, rd_ack, buf_valid, chain_done, busy, err, notify;
  logic [63:0] rd_addr;
  logic [127:0] rd_data;
  logic [15:0] chain_head, seen_idx;
  logic [1:0] err_code;
  sqw_pkg::sqw_buf_s buf_out;
  int fail_count = 0;
  int num_checks = 0;

  // queue of 8 entries: a power of two small enough to loop around quickly
  sqw_walker i_dut (.clk, .rst_n, .qsz_log2(4'h3), .desc_base(DBASE), .ring_base(RBASE),
    .offer_idx, .err_clr, .rd_req, .rd_addr, .rd_ack, .rd_data, .buf_valid, .buf_out,
    .buf_ready, .chain_done, .chain_head, .seen_idx, .busy, .err, .err_code, .event_idx_en,
    .drv_flags, .used_event, .used_wr, .used_idx, .notify);
  sqw_mem_model i_mem (.clk, .rd_req, .rd_addr, .slow, .rd_ack, .rd_data);

  always #25 clk = ~clk;

  // a writable buffer is never fetched: the walker reads rings and tables only
  always @(posedge clk) begin
    if (rd_req === 1'b1 && rd_addr === WBUF) begin
      fail_count++;
      $display("[FAIL] rd_addr expected not %h seen %h", WBUF, rd_addr);
    end
  end

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_buf(input sqw_pkg::sqw_buf_s exp);
    num_checks++;
    if (buf_out !== exp) begin
      fail_count++;
      $display("[FAIL] buf_out expected %h seen %h", exp, buf_out);
    end
  endtask

  task automatic desc(input logic [63:0] at, input logic [63:0] ad, input logic [31:0] ln,
                      input logic [15:0] fl, input logic [15:0] lk);
    i_mem.put(at, {lk, fl, ln, ad}, 16);
  endtask

  // ring slot is the index modulo 8; the index only ever counts up
  task automatic offer(input logic [15:0] head);
    i_mem.put(RBASE + 64'h4 + {60'h0, offer_idx[2:0], 1'b0}, {112'h0, head}, 2);
    offer_idx = offer_idx + 16'h0001;
  endtask

  // the far side stalls two cycles before it accepts each buffer
  task automatic take(input sqw_pkg::sqw_buf_s exp, input logic last);
    int i;
    for (i = 0; i < 100 && buf_valid !== 1'b1; i++)
      step(1);
    step(2);
    // a stalled walker would leave the last buffer on buf_out and still match
    chk_val("buf_valid", 64'h1, 64'(buf_valid));
    chk_buf(exp);
    buf_ready = 1'b1;
    step(1);
    buf_ready = 1'b0;
    chk_val("chain_done", 64'(last), 64'(chain_done));
  endtask

  task automatic wait_err(input logic [1:0] code, input logic [15:0] seen);
    int i;
    for (i = 0; i < 200 && err !== 1'b1; i++)
      step(1);
    step(3);
    chk_val("err", 64'h1, 64'(err));
    chk_val("err_code", 64'(code), 64'(err_code));
    chk_val("rd_req", 64'h0, 64'(rd_req));
    err_clr = 1'b1;
    step(1);
    err_clr = 1'b0;
    step(2);
    chk_val("err", 64'h0, 64'(err));
    chk_val("seen_idx", 64'(seen), 64'(seen_idx));
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_plain;
    desc(DBASE + 64'h20, 64'h1_2345_6780, 32'h40, 16'h0001, 16'h0005);
    desc(DBASE + 64'h50, WBUF, 32'h10, 16'h0002, 16'h0000);
    offer(16'h0002);
    take('{64'h1_2345_6780, 32'h40, 1'b0, 1'b0}, 1'b0);
    take('{WBUF, 32'h10, 1'b1, 1'b0}, 1'b1);
    chk_val("chain_head", 64'h2, 64'(chain_head));
    chk_val("seen_idx", 64'h1, 64'(seen_idx));
    $display("test plain chain finished");
  endtask

  // plain descriptor then a table pointer whose write bit must be ignored
  task automatic t_indirect;
    slow = 1'b1;
    desc(DBASE + 64'h40, 64'hA000, 32'h8, 16'h0001, 16'h0006);
    desc(DBASE + 64'h60, 64'h3000, 32'h20, 16'h0006, 16'h0000);
    desc(64'h3000, 64'hB000, 32'h4, 16'h0001, 16'h0001);
    desc(64'h3010, WBUF, 32'h100, 16'h0002, 16'h0000);
    offer(16'h0004);
    take('{64'hA000, 32'h8, 1'b0, 1'b0}, 1'b0);
    take('{64'hB000, 32'h4, 1'b0, 1'b1}, 1'b0);
    take('{WBUF, 32'h100, 1'b1, 1'b1}, 1'b1);
    chk_val("seen_idx", 64'h2, 64'(seen_idx));
    slow = 1'b0;
    $display("test indirect table finished");
  endtask

  // bad flags, then a looping chain the driver should never build
  task automatic t_fault;
    desc(DBASE + 64'h70, 64'hC000, 32'h10, 16'h0005, 16'h0000);
    offer(16'h0007);
    wait_err(2'h2, 16'h0003);
    desc(DBASE, 64'hD000, 32'h4, 16'h0001, 16'h0001);
    desc(DBASE + 64'h10, 64'hD000, 32'h4, 16'h0001, 16'h0000);
    offer(16'h0000);
    repeat (8) take('{64'hD000, 32'h4, 1'b0, 1'b0}, 1'b0);
    wait_err(2'h1, 16'h0004);
    // a head beyond the table is refused before any descriptor fetch
    offer(16'h0008);
    wait_err(2'h3, 16'h0005);
    // a table entry that points at yet another table is refused
    desc(DBASE + 64'h30, 64'h3100, 32'h10, 16'h0004, 16'h0000);
    desc(64'h3100, 64'hE000, 32'h10, 16'h0004, 16'h0000);
    offer(16'h0003);
    wait_err(2'h2, 16'h0006);
    $display("test chain faults finished");
  endtask

  // fields: event index on, driver flags, threshold, used index, expected
  task automatic t_notify;
    logic e;
    logic [49:0] tbl [6] = '{{1'b0, 16'h0000, 16'h0005, 16'h0009, 1'b1},
      {1'b0, 16'h0001, 16'h0009, 16'h0009, 1'b0}, {1'b1, 16'h0001, 16'h0009, 16'h0009, 1'b1},
      {1'b1, 16'h0000, 16'h0009, 16'h0008, 1'b0}, {1'b1, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b1},
      {1'b1, 16'h0000, 16'h0000, 16'hFFFF, 1'b0}};
    for (int i = 0; i < 6; i++) begin
      {event_idx_en, drv_flags, used_event, used_idx, e} = tbl[i];
      used_wr = 1'b1;
      step(1);
      used_wr = 1'b0;
      chk_val("notify", 64'(e), 64'(notify));
      step(1);
      chk_val("notify", 64'h0, 64'(notify));
    end
    $display("test notification finished");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // reset held for four cycles, then the scenarios in turn
  initial begin
    step(4);
    rst_n = 1'b1;
    step(1);
    chk_val("busy", 64'h0, 64'(busy));
    t_plain;
    t_indirect;
    t_fault;
    t_notify;
    complete_run;
  end

  // the scenarios need well under a thousand cycles; allow twenty thousand
  initial begin
    #1000000;
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    complete_run;
  end
endmodule
